// File: qsf_consts.vh
// Purpose: shared constants of the quad serial flash controller
// Assumes: 25 MHz system clock
// Notes: serial clock is derived by dividing the system clock
`ifndef QSF_CONSTS_VH
`define QSF_CONSTS_VH

// Timing
`define QSF_CLK_PERIOD_NS 40
`define QSF_SCLK_PERIOD_NS 320
`define QSF_HALF_CYC (`QSF_SCLK_PERIOD_NS / (2 * `QSF_CLK_PERIOD_NS))

// Transfer layout
`define QSF_CMD_QREAD 8'hEB
`define QSF_DIR_LEN 3'h4
`define QSF_CMD_NIB 5'h2
`define QSF_ADDR_NIB 5'h6
`define QSF_CS_BIT 24

// Reset values
`define QSF_CS_IDLE 2'h3
`define QSF_NIB_RST 4'h0

`endif

// File: qsf_fifo.v
// Purpose: small synchronous FIFO for read data
// Assumes: single clock, synchronous active-low reset
// Notes: full, valid and the head word are registers
`timescale 1ns/1ps
module qsf_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst_b,
   // Fill side
   input wire i_valid,
   output wire o_ready,
   input wire [WIDTH-1:0] i_data,
   // Drain side
   output wire o_valid,
   input wire i_ready,
   output wire [WIDTH-1:0] o_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [WIDTH-1:0] head;
   reg [AW-1:0] wptr;
   reg [AW-1:0] rptr;
   reg [AW:0] count;
   reg full;
   reg avail;
   wire push;
   wire pop;
   wire [AW-1:0] next_rptr;
   wire [AW:0] next_count;

   assign push = i_valid && !full;
   assign pop = i_ready && avail;
   assign o_ready = !full;
   assign o_valid = avail;
   assign o_data = head;
   assign next_rptr = !pop ? rptr : (rptr == DEPTH - 1) ? {AW{1'b0}} : rptr + 1'b1;
   assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   // Head word is registered so the drain side comes straight from flops
   always @(posedge i_clk) begin
      if (push) begin
         mem[wptr] <= i_data;
      end
      head <= (push && wptr == next_rptr) ? i_data : mem[next_rptr];
   end

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         wptr <= {AW{1'b0}};
         rptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         full <= 1'b0;
         avail <= 1'b0;
      end else begin
         if (push) begin
            wptr <= (wptr == DEPTH - 1) ? {AW{1'b0}} : wptr + 1'b1;
         end
         rptr <= next_rptr;
         count <= next_count;
         full <= (next_count == DEPTH);
         avail <= (next_count != {(AW+1){1'b0}});
      end
   end
endmodule

// File: qsf_ctrl.v
// Purpose: quad serial flash controller, direct and indirect transfers
// Assumes: loopback clock and data pins arrive asynchronously
// Notes: serial clock period is fixed by the divider constant
// Function
// RULE1: Two chip selects; only the one addressed by the transfer goes active.
// RULE2: Direct read requests and software-triggered indirect transfers both supported.
// RULE3: Clock mode 0 only; serial clock idles low between transfers.
// RULE4: Read data is sampled on the falling serial clock edge.
// RULE5: Capture is timed by the looped-back clock to cancel skew.
// RULE6: Four two-way data lines; flash holds data stable around falling edge.
// RULE7: Chip select goes active a programmed number of periods before first fall.
// RULE8: Chip select goes inactive a programmed number of periods after last fall.
// RULE9: First data value is driven one full period before first falling edge.
// RULE10: Indirect completion shows on a status flag software can poll.
`timescale 1ns/1ps
`include "qsf_consts.vh"
module qsf_ctrl (
   // Clock and reset
   input wire I_CLK,
   input wire I_RST_B,
   // Timing configuration, in serial clock periods
   input wire [3:0] I_LEAD,
   input wire [3:0] I_TAIL,
   input wire [3:0] I_DUMMY,
   // Direct read request
   input wire I_DIR_REQ,
   input wire [24:0] I_DIR_ADDR,
   // Indirect transfer
   input wire I_IND_GO,
   input wire I_IND_CS,
   input wire [7:0] I_IND_CMD,
   input wire [23:0] I_IND_ADDR,
   input wire I_IND_WR,
   input wire [2:0] I_IND_LEN,
   input wire [31:0] I_IND_WDATA,
   // Status
   output reg O_BUSY,
   output reg O_IND_DONE,
   // Read data stream
   output wire O_RD_VALID,
   input wire I_RD_READY,
   output wire [7:0] O_RD_DATA,
   // Flash pins
   output reg O_SCLK,
   output reg [1:0] O_CS_B,
   output reg [3:0] O_D_OUT,
   output reg [3:0] O_D_OE,
   input wire [3:0] I_D_IN,
   input wire I_SCLK_LB
);
   localparam ST_IDLE = 2'h0;
   localparam ST_LEAD = 2'h1;
   localparam ST_SHIFT = 2'h2;
   localparam ST_TAIL = 2'h3;
   localparam integer HALF_N = `QSF_HALF_CYC;
   localparam [2:0] HALF = HALF_N[2:0];

   reg [1:0] state;
   reg [2:0] hc;
   reg [4:0] cnt;
   reg [63:0] sh;
   reg [4:0] out_left;
   reg [3:0] dum_left;
   reg [3:0] rd_left;
   reg ind_xfer;
   reg pend;
   // Synchronisers and capture
   reg lb_s1;
   reg lb_s2;
   reg lb_s3;
   reg [3:0] d_s1;
   reg [3:0] d_s2;
   reg [3:0] d_s3;
   reg [4:0] skip;
   reg [3:0] cap_left;
   reg half;
   reg [3:0] hi;
   reg push;
   reg [7:0] push_data;

   wire tick;
   wire lb_fall;
   wire fifo_ready;
   wire dir_go;
   wire ind_go;
   wire [2:0] len;
   wire [4:0] lead_h;
   wire [4:0] tail_h;
   wire rd_phase;
   wire stall;

   assign tick = (hc == HALF - 3'h1);
   assign lb_fall = !lb_s2 && lb_s3;
   assign dir_go = I_DIR_REQ;
   assign ind_go = I_IND_GO && !I_DIR_REQ;
   assign len = dir_go ? `QSF_DIR_LEN : I_IND_LEN;
   // Zero lead or tail is treated as one period
   assign lead_h = (I_LEAD == 4'h0) ? 5'h0 : {I_LEAD, 1'b0} - 5'h2;
   assign tail_h = (I_TAIL == 4'h0) ? 5'h2 : {I_TAIL, 1'b0};
   assign rd_phase = (out_left == 5'h0) && (dum_left == 4'h0);
   // Hold the clock low at a byte start until the FIFO can take it
   assign stall = rd_phase && !rd_left[0] && (!fifo_ready || pend);

   qsf_fifo #(
      .WIDTH(8),
      .DEPTH(4),
      .AW(2)
   ) u_fifo (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_valid(push),
      .o_ready(fifo_ready),
      .i_data(push_data),
      .o_valid(O_RD_VALID),
      .i_ready(I_RD_READY),
      .o_data(O_RD_DATA)
   );

   // Loopback clock and data share the same synchroniser depth
   always @(posedge I_CLK) begin
      if (!I_RST_B) begin
         lb_s1 <= 1'b0;
         lb_s2 <= 1'b0;
         lb_s3 <= 1'b0;
         d_s1 <= `QSF_NIB_RST;
         d_s2 <= `QSF_NIB_RST;
         d_s3 <= `QSF_NIB_RST;
      end else begin
         lb_s1 <= I_SCLK_LB; // RULE5
         lb_s2 <= lb_s1;
         lb_s3 <= lb_s2;
         d_s1 <= I_D_IN;
         d_s2 <= d_s1;
         d_s3 <= d_s2;
      end
   end

   // Capture: d_s3 was sampled with lb_s3 high, just before the fall
   always @(posedge I_CLK) begin
      if (!I_RST_B) begin
         skip <= 5'h0;
         cap_left <= 4'h0;
         half <= 1'b0;
         hi <= `QSF_NIB_RST;
         push <= 1'b0;
         push_data <= 8'h00;
      end else begin
         push <= 1'b0;
         if (state == ST_IDLE && (dir_go || ind_go)) begin
            skip <= `QSF_CMD_NIB + `QSF_ADDR_NIB + {1'b0, I_DUMMY} +
               ((ind_go && I_IND_WR) ? {1'b0, len, 1'b0} : 5'h0);
            cap_left <= (ind_go && I_IND_WR) ? 4'h0 : {len, 1'b0};
            half <= 1'b0;
         end else if (lb_fall) begin
            if (skip != 5'h0) begin
               skip <= skip - 5'h1;
            end else if (cap_left != 4'h0) begin
               cap_left <= cap_left - 4'h1;
               if (!half) begin
                  hi <= d_s3; // RULE4
                  half <= 1'b1;
               end else begin
                  push_data <= {hi, d_s3}; // RULE6
                  push <= 1'b1;
                  half <= 1'b0;
               end
            end
         end
      end
   end

   // Sequencer
   always @(posedge I_CLK) begin
      if (!I_RST_B) begin
         state <= ST_IDLE;
         hc <= 3'h0;
         cnt <= 5'h0;
         sh <= 64'h0;
         out_left <= 5'h0;
         dum_left <= 4'h0;
         rd_left <= 4'h0;
         ind_xfer <= 1'b0;
         pend <= 1'b0;
         O_BUSY <= 1'b0;
         O_IND_DONE <= 1'b0;
         O_SCLK <= 1'b0;
         O_CS_B <= `QSF_CS_IDLE;
         O_D_OUT <= `QSF_NIB_RST;
         O_D_OE <= 4'h0;
      end else begin
         hc <= tick ? 3'h0 : hc + 3'h1;
         if (push) begin
            pend <= 1'b0;
         end
         case (state)
            ST_IDLE: begin
               O_SCLK <= 1'b0; // RULE3
               if (dir_go || ind_go) begin // RULE2
                  O_BUSY <= 1'b1;
                  hc <= 3'h0;
                  cnt <= lead_h;
                  ind_xfer <= ind_go;
                  if (ind_go) begin
                     O_IND_DONE <= 1'b0;
                  end
                  if (dir_go) begin
                     O_CS_B <= I_DIR_ADDR[`QSF_CS_BIT] ? 2'h1 : 2'h2; // RULE1
                     sh <= {`QSF_CMD_QREAD, I_DIR_ADDR[23:0], 32'h0};
                  end else begin
                     O_CS_B <= I_IND_CS ? 2'h1 : 2'h2; // RULE1
                     sh <= {I_IND_CMD, I_IND_ADDR, I_IND_WDATA};
                  end
                  out_left <= `QSF_CMD_NIB + `QSF_ADDR_NIB +
                     ((ind_go && I_IND_WR) ? {1'b0, len, 1'b0} : 5'h0);
                  dum_left <= I_DUMMY;
                  rd_left <= (ind_go && I_IND_WR) ? 4'h0 : {len, 1'b0};
                  state <= ST_LEAD;
               end
            end
            ST_LEAD: begin
               if (cnt == 5'h0) begin
                  // One period before the first fall
                  O_D_OUT <= sh[63:60]; // RULE9
                  O_D_OE <= 4'hF;
                  sh <= {sh[59:0], 4'h0};
                  hc <= 3'h0;
                  state <= ST_SHIFT; // RULE7
               end else if (tick) begin
                  cnt <= cnt - 5'h1;
               end
            end
            ST_SHIFT: begin
               if (tick) begin
                  if (!O_SCLK) begin
                     if (!stall) begin
                        O_SCLK <= 1'b1;
                     end
                  end else begin
                     O_SCLK <= 1'b0;
                     if (out_left != 5'h0) begin
                        out_left <= out_left - 5'h1;
                        if (out_left == 5'h1) begin
                           // Release the lines for turnaround
                           O_D_OE <= 4'h0;
                        end else begin
                           O_D_OUT <= sh[63:60];
                           sh <= {sh[59:0], 4'h0};
                        end
                     end else if (dum_left != 4'h0) begin
                        dum_left <= dum_left - 4'h1;
                     end else if (rd_left != 4'h0) begin
                        rd_left <= rd_left - 4'h1;
                        if (rd_left[0]) begin
                           pend <= 1'b1;
                        end
                     end
                     if ((out_left <= 5'h1) && (dum_left == 4'h0 ||
                        (out_left == 5'h0 && dum_left == 4'h1 && rd_left == 4'h0)) &&
                        (rd_left == 4'h0 || (rd_phase && rd_left == 4'h1))) begin
                        cnt <= tail_h;
                        state <= ST_TAIL;
                     end
                  end
               end
            end
            ST_TAIL: begin
               O_D_OE <= 4'h0;
               if (tick) begin
                  if (cnt <= 5'h1) begin
                     O_CS_B <= `QSF_CS_IDLE; // RULE8
                     O_BUSY <= 1'b0;
                     if (ind_xfer) begin
                        O_IND_DONE <= 1'b1; // RULE10
                     end
                     state <= ST_IDLE;
                  end else begin
                     cnt <= cnt - 5'h1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// File: qsf_ctrl_props.sv
// Purpose: port checks of the flash controller
// Assumes: serial clock period of 8 system clocks
// Notes: lead and tail are measured in system clocks
`timescale 1ns/1ps
module qsf_ctrl_props (
   // Clock and reset
   input wire I_CLK,
   input wire I_RST_B,
   // Watched ports
   input wire [3:0] I_LEAD,
   input wire [3:0] I_TAIL,
   input wire I_DIR_REQ,
   input wire [24:0] I_DIR_ADDR,
   input wire I_IND_GO,
   input wire I_IND_CS,
   input wire I_RD_READY,
   input wire O_BUSY,
   input wire O_IND_DONE,
   input wire O_RD_VALID,
   input wire [7:0] O_RD_DATA,
   input wire O_SCLK,
   input wire [1:0] O_CS_B,
   input wire [3:0] O_D_OE
);
   reg sclk_q;
   reg seen;
   reg [7:0] since_cs;
   reg [7:0] since_fall;
   wire fall = sclk_q && !O_SCLK;
   wire idle = O_CS_B == 2'h3;
   wire [7:0] lead = {1'b0, (I_LEAD == 4'h0) ? 4'h1 : I_LEAD, 3'h0} + 8'h01;
   wire [7:0] tail = {1'b0, (I_TAIL == 4'h0) ? 4'h1 : I_TAIL, 3'h0};
   always @(posedge I_CLK) begin
      if (!I_RST_B || idle) begin
         since_cs <= 8'h00;
         seen <= 1'b0;
      end else begin
         since_cs <= since_cs + 8'h01;
         seen <= seen | fall;
      end
      sclk_q <= I_RST_B & O_SCLK;
      since_fall <= (fall || !I_RST_B) ? 8'h01 : since_fall + 8'h01;
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   a_cs_one: assert property (O_CS_B != 2'h0)
      else $error("both selects active");
   a_sclk_idle: assert property (idle |-> !O_SCLK)
      else $error("clock not low while idle");
   a_dir_sel: assert property (I_DIR_REQ && !O_BUSY && idle |=>
      O_BUSY && O_CS_B == ($past(I_DIR_ADDR[24]) ? 2'h1 : 2'h2)) else $error("direct select");
   a_ind_sel: assert property (I_IND_GO && !I_DIR_REQ && !O_BUSY && idle |=>
      !O_IND_DONE && O_CS_B == ($past(I_IND_CS) ? 2'h1 : 2'h2)) else $error("indirect select");
   a_cs_lead: assert property (fall && !seen |-> since_cs == lead)
      else $error("select lead wrong");
   a_cs_tail: assert property (idle && $past(O_CS_B) != 2'h3 |-> since_fall == tail)
      else $error("select tail wrong");
   a_first_nib: assert property ($rose(O_D_OE[1]) && !seen |->
      !O_SCLK ##4 O_SCLK [*4] ##1 !O_SCLK) else $error("first nibble not a period early");
   a_rd_hold: assert property (O_RD_VALID && !I_RD_READY |=> O_RD_VALID && $stable(O_RD_DATA))
      else $error("read head changed untaken");
endmodule
bind qsf_ctrl qsf_ctrl_props i_qsf_ctrl_props (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
   .I_LEAD(I_LEAD), .I_TAIL(I_TAIL), .I_DIR_REQ(I_DIR_REQ), .I_DIR_ADDR(I_DIR_ADDR),
   .I_IND_GO(I_IND_GO), .I_IND_CS(I_IND_CS), .I_RD_READY(I_RD_READY), .O_BUSY(O_BUSY),
   .O_IND_DONE(O_IND_DONE), .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA),
   .O_SCLK(O_SCLK), .O_CS_B(O_CS_B), .O_D_OE(O_D_OE));

// File: qsf_flash_model.sv
// Purpose: behavioural quad flash on the link
// Assumes: clock mode 0; read byte n is address low byte plus n
// Notes: command 8'h32 is taken as a write and never answered
`timescale 1ns/1ps
module qsf_flash_model (
   // Link
   input wire logic i_sclk,
   input wire logic [1:0] i_cs_b,
   input wire logic [3:0] i_line,
   input wire logic [3:0] i_dummy,
   output logic [3:0] o_d,
   // Frame as seen, for the bench
   output logic [31:0] o_hdr,
   output logic [31:0] o_wdat
);
   logic [31:0] hdr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [7:0] b;
   int rises = 0;
   int falls = 0;
   int n;
   wire idle = &i_cs_b;
   initial o_d = 4'h5;
   assign o_hdr = hdr;
   assign o_wdat = wdat;
   // Released lines show the inverse, never a stale copy
   always @(posedge idle) begin
      rises = 0;
      falls = 0;
      o_d = ~o_d;
   end
   always @(posedge i_sclk) if (!idle && rises < 16) begin
      if (rises < 8)
         hdr = {hdr[27:0], i_line};
      else
         wdat = {wdat[27:0], i_line};
      rises = rises + 1;
   end
   always @(negedge i_sclk) if (!idle) begin
      falls = falls + 1;
      n = falls - 8 - i_dummy;
      b = hdr[7:0] + n[8:1];
      // Old nibble held 1 ns past the fall
      if (n >= 0 && hdr[31:24] != 8'h32) o_d <= #1 (n[0] ? b[3:0] : b[7:4]);
   end
endmodule

// File: test_qsf_ctrl.sv
// Purpose: self-checking bench for the flash controller
// Assumes: flash model on the far side, loopback tied to the clock
// Notes: read bytes follow the address low byte
`timescale 1ns/1ps
module test_qsf_ctrl;
   logic I_CLK = 1'b0;
   logic I_RST_B = 1'b0;
   logic [3:0] I_LEAD = 4'h0;
   logic [3:0] I_TAIL = 4'h0;
   logic [3:0] I_DUMMY = 4'h2;
   logic I_DIR_REQ = 1'b0;
   logic [24:0] I_DIR_ADDR = 25'h0;
   logic I_IND_GO = 1'b0;
   logic I_IND_CS = 1'b0;
   logic [7:0] I_IND_CMD = 8'h0;
   logic [23:0] I_IND_ADDR = 24'h0;
   logic I_IND_WR = 1'b0;
   logic [2:0] I_IND_LEN = 3'h0;
   logic [31:0] I_IND_WDATA = 32'hA5C39617;
   logic I_RD_READY = 1'b0;
   wire O_BUSY, O_IND_DONE, O_RD_VALID, O_SCLK;
   wire [7:0] O_RD_DATA;
   wire [31:0] m_hdr, m_wdat;
   wire [1:0] O_CS_B;
   wire [3:0] O_D_OUT, O_D_OE, m_d;
   wire [3:0] d_line = (O_D_OE & O_D_OUT) | (~O_D_OE & m_d);
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;
   always #20 I_CLK = ~I_CLK;
   qsf_ctrl i_qsf_ctrl (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_LEAD(I_LEAD), .I_TAIL(I_TAIL),
      .I_DUMMY(I_DUMMY), .I_DIR_REQ(I_DIR_REQ), .I_DIR_ADDR(I_DIR_ADDR), .I_IND_GO(I_IND_GO),
      .I_IND_CS(I_IND_CS), .I_IND_CMD(I_IND_CMD), .I_IND_ADDR(I_IND_ADDR), .I_IND_WR(I_IND_WR),
      .I_IND_LEN(I_IND_LEN), .I_IND_WDATA(I_IND_WDATA), .O_BUSY(O_BUSY),
      .O_IND_DONE(O_IND_DONE), .O_RD_VALID(O_RD_VALID), .I_RD_READY(I_RD_READY),
      .O_RD_DATA(O_RD_DATA), .O_SCLK(O_SCLK), .O_CS_B(O_CS_B), .O_D_OUT(O_D_OUT),
      .O_D_OE(O_D_OE), .I_D_IN(d_line), .I_SCLK_LB(O_SCLK));
   qsf_flash_model i_qsf_flash_model (.i_sclk(O_SCLK), .i_cs_b(O_CS_B), .i_line(d_line),
      .i_dummy(I_DUMMY), .o_d(m_d), .o_hdr(m_hdr), .o_wdat(m_wdat));
   task automatic end_sim;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wait_idle;
      for (int n = 0; n < 4000 && O_BUSY !== 1'b0; n++) begin
         @(posedge I_CLK);
         #1;
      end
      chk(O_BUSY, 0);
   endtask
   task automatic pop(input logic [7:0] exp);
      for (int n = 0; n < 4000 && O_RD_VALID !== 1'b1; n++) begin
         @(posedge I_CLK);
         #1;
      end
      chk(O_RD_VALID, 1);
      chk(O_RD_DATA, exp);
      I_RD_READY = 1'b1;
      @(posedge I_CLK);
      #1 I_RD_READY = 1'b0;
      // Let an edge pass so a following pop never re-raises ready at once
      @(posedge I_CLK);
      #1;
   endtask
   task automatic rd_dir(input logic [24:0] a);
      I_DIR_ADDR = a;
      I_DIR_REQ = 1'b1;
      @(posedge I_CLK);
      #1 I_DIR_REQ = 1'b0;
   endtask
   task automatic ind(input logic cs, input logic wr, input logic [2:0] len, input logic [7:0] a);
      I_IND_CS = cs;
      I_IND_WR = wr;
      I_IND_LEN = len;
      I_IND_ADDR = {16'h0012, a};
      I_IND_CMD = wr ? 8'h32 : 8'hEB;
      I_IND_GO = 1'b1;
      @(posedge I_CLK);
      #1 I_IND_GO = 1'b0;
      chk(O_IND_DONE, 0);
      chk(O_CS_B, cs ? 2'h1 : 2'h2);
      wait_idle;
      chk(O_IND_DONE, 1);
      for (int i = 0; i < len && !wr; i++) pop(a + i[7:0]);
   endtask
   task automatic t_direct;
      for (int c = 0; c < 2; c++) begin
         rd_dir({c[0], 24'h1234FE});
         chk(O_CS_B, c ? 2'h1 : 2'h2);
         wait_idle;
         chk(m_hdr, {8'hEB, 24'h1234FE});
         for (int i = 0; i < 4; i++) pop(8'hFE + i[7:0]);
      end
   endtask
   task automatic t_indirect;
      for (int l = 0; l < 5; l++) ind(l[0], 1'b0, l[2:0], 8'h40 + l[7:0]);
      ind(1'b1, 1'b1, 3'h4, 8'h00);
      chk(m_hdr, {8'h32, 24'h001200});
      chk(m_wdat, I_IND_WDATA);
   endtask
   // A trigger during a busy transfer must leave the done flag alone
   task automatic t_refuse;
      rd_dir(25'h0000010);
      I_IND_GO = 1'b1;
      @(posedge I_CLK);
      #1 I_IND_GO = 1'b0;
      wait_idle;
      chk(O_IND_DONE, 1);
      for (int i = 0; i < 4; i++) pop(8'h10 + i[7:0]);
   endtask
   task automatic t_stall;
      rd_dir(25'h1000020);
      wait_idle;
      rd_dir(25'h0000080);
      repeat (200) @(posedge I_CLK);
      #1 chk(O_BUSY, 1);
      for (int i = 0; i < 8; i++) pop((i < 4) ? 8'h20 + i[7:0] : 8'h7C + i[7:0]);
      wait_idle;
   endtask
   always @(posedge I_CLK) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_sim;
      end
   end
   initial begin
      repeat (2) @(posedge I_CLK);
      #1 chk({O_CS_B, O_SCLK, O_D_OE, O_BUSY, O_IND_DONE, O_RD_VALID}, 32'h300);
      I_RST_B = 1'b1;
      t_direct;
      I_LEAD = 4'h3;
      I_TAIL = 4'h2;
      I_DUMMY = 4'h1;
      t_indirect;
      t_refuse;
      t_stall;
      end_sim;
   end
endmodule
